// [hdl/udcc_top.sv]
// Purpose : Mode control, compare-one and two capture/compare channels of the counter unit
// Assumes : Counter core, compare-zero, edge select and pin filter sit outside and feed
//           this block with count, direction, match, underflow and edge settings
// Notes   : All pins sampled as synchronous; every output comes from a flip-flop

`timescale 1ns/10ps
`default_nettype none

module udcc_top (
  input  wire logic        I_CLOCK,                   // 20 MHz system clock
  input  wire logic        I_RST,                     // Synchronous reset, active high
  input  wire logic [15:0] i_ADDR,                    // CPU address
  input  wire logic [15:0] i_WDATA,                   // CPU write data
  input  wire logic        i_WR,                      // CPU write strobe, one cycle
  input  wire logic        i_RD,                      // CPU read strobe, one cycle
  input  wire logic        i_WORD,                    // 1 = 16-bit access, 0 = 8-bit
  input  wire logic [15:0] i_COUNT,                   // Main counter value
  input  wire logic        i_COUNT_DOWN,              // Counter is counting down
  input  wire logic        i_COMPARE_ZERO_MATCH,      // Compare-zero match pulse
  input  wire logic        i_UNDERFLOW,               // Counter underflow pulse
  input  wire logic        i_EXT_CLEAR,               // Valid edge on external clear pin
  input  wire logic        i_PWM_ACTIVE,              // Timer output active phase
  input  wire logic        i_CHAN_ZERO_CAPTURE_PIN,   // Channel zero capture pin
  input  wire logic        i_CHAN_ONE_CAPTURE_PIN,    // Channel one capture pin
  input  wire logic [1:0]  i_CHAN_ZERO_EDGE_SEL,      // Channel zero edge select
  input  wire logic [1:0]  i_CHAN_ONE_EDGE_SEL,       // Channel one edge select
  output logic      [15:0] o_RDATA,                   // CPU read data
  output logic             o_COUNT_ENABLE,            // Counting allowed
  output logic             o_OPERATING_MODE,          // 1 = up/down counting
  output logic             o_SUB_MODE,                // 1 = mode B
  output logic             o_CLEAR,                   // Counter clear pulse
  output logic             o_RELOAD,                  // Compare-zero reload pulse
  output logic             o_TIMER_OUT,               // Timer output pin
  output logic             o_COMPARE_ONE_IRQ,         // Compare-one interrupt pulse
  output logic             o_CHAN_ZERO_IRQ,           // Channel zero interrupt pulse
  output logic             o_CHAN_ONE_IRQ             // Channel one interrupt pulse
);

  logic [7:0]  unit_mode_reg;
  logic [7:0]  count_control_reg;
  logic [7:0]  capcomp_mode_reg;
  logic [15:0] compare_one_reg;
  logic [15:0] compare_one_next;
  logic        cm1_prev_reg;
  logic [15:0] rdata_reg;
  logic        clear_reg;
  logic        reload_reg;
  logic        timer_out_reg;
  logic        cm1_irq_reg;
  logic [15:0] chan_value [2];
  logic [1:0]  chan_irq;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire operating_mode = unit_mode_reg[udcc_pkg::UM_OPERATING_MODE_BIT];
  wire sub_mode       = unit_mode_reg[udcc_pkg::UM_SUB_MODE_BIT];
  wire timer_out_en   = unit_mode_reg[udcc_pkg::UM_TIMER_OUT_EN_BIT];
  wire polarity       = unit_mode_reg[udcc_pkg::UM_POLARITY_BIT];
  wire count_enable   = count_control_reg[udcc_pkg::CC_COUNT_ENABLE_BIT];
  wire reload_enable  = count_control_reg[udcc_pkg::CC_RELOAD_ENABLE_BIT];
  wire clear_enable   = count_control_reg[udcc_pkg::CC_CLEAR_ENABLE_BIT];
  wire [1:0] clr_src  = {count_control_reg[udcc_pkg::CC_CLEAR_SRC_HI_BIT],
                         count_control_reg[udcc_pkg::CC_CLEAR_SRC_LO_BIT]};
  wire mode_a         = operating_mode & ~sub_mode;
  wire mode_b         = operating_mode & sub_mode;
  wire counting_up    = ~i_COUNT_DOWN;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_ccr = (i_ADDR == udcc_pkg::ADDR_CAPCOMP_MODE);
  wire sel_um  = (i_ADDR == udcc_pkg::ADDR_UNIT_MODE);
  wire sel_ctl = (i_ADDR == udcc_pkg::ADDR_COUNT_CONTROL);
  wire sel_cm1 = (i_ADDR == udcc_pkg::ADDR_COMPARE_ONE);
  wire sel_cc0 = (i_ADDR == udcc_pkg::ADDR_CAPCOMP_ZERO);
  wire sel_cc1 = (i_ADDR == udcc_pkg::ADDR_CAPCOMP_ONE);
  wire wr_cm1  = i_WR & sel_cm1;

  // Word or low byte write into compare-one
  assign compare_one_next = (wr_cm1 & i_WORD)  ? i_WDATA :
                            (wr_cm1 & ~i_WORD) ? {compare_one_reg[15:8], i_WDATA[7:0]} :
                            compare_one_reg;

  // Control registers; reserved bits never store, so they read zero
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      unit_mode_reg     <= udcc_pkg::UNIT_MODE_RST;
      count_control_reg <= udcc_pkg::COUNT_CONTROL_RST;
      capcomp_mode_reg  <= udcc_pkg::CAPCOMP_MODE_RST;
      compare_one_reg   <= udcc_pkg::VALUE_RST;
    end else begin
      if (i_WR & sel_um)
        unit_mode_reg <= i_WDATA[7:0] & udcc_pkg::UNIT_MODE_MASK;
      if (i_WR & sel_ctl)
        count_control_reg <= i_WDATA[7:0] & udcc_pkg::COUNT_CONTROL_MASK;
      if (i_WR & sel_ccr)
        capcomp_mode_reg <= i_WDATA[7:0] & udcc_pkg::CAPCOMP_MODE_MASK;
      compare_one_reg <= compare_one_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Values are sampled at the read edge; a back-to-back read of a channel
  // may see a capture landing in between, which software must avoid
  wire [15:0] rd_word = sel_ccr ? {8'h00, capcomp_mode_reg} :
                        sel_um  ? {8'h00, unit_mode_reg} :
                        sel_ctl ? {8'h00, count_control_reg} :
                        sel_cm1 ? compare_one_reg :
                        sel_cc0 ? chan_value[0] :
                        sel_cc1 ? chan_value[1] : 16'h0000;
  wire [15:0] rd_sized = i_WORD ? rd_word : {8'h00, rd_word[7:0]};

  always_ff @(posedge I_CLOCK) begin
    if (I_RST)
      rdata_reg <= udcc_pkg::RDATA_RST;
    else if (i_RD)
      rdata_reg <= rd_sized;
  end

  // ----------------------------------------------------------------
  // Capture/compare channels
  // ----------------------------------------------------------------
  // Pins shared with the direction input and the clear input are cut off here
  wire clear_pin_used = mode_a & ((clr_src == udcc_pkg::UDCC_CLR_EXT_ONLY) |
                                  (clr_src == udcc_pkg::UDCC_CLR_EITHER));
  wire [1:0] pin_free = {~clear_pin_used, ~operating_mode};
  wire [1:0] chan_pin = {i_CHAN_ONE_CAPTURE_PIN, i_CHAN_ZERO_CAPTURE_PIN};
  wire [3:0] chan_sel = {i_CHAN_ONE_EDGE_SEL, i_CHAN_ZERO_EDGE_SEL};
  wire [1:0] wr_chan  = {i_WR & sel_cc1, i_WR & sel_cc0};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      udcc_chan u_chan (
        .i_clk      (I_CLOCK),
        .i_rst      (I_RST),
        .i_pin      (chan_pin[ch]),
        .i_edge_sel (chan_sel[2*ch+1 -: 2]),
        .i_cap_en   (count_enable & pin_free[ch]),
        .i_cmp_mode (capcomp_mode_reg[ch]),
        .i_count    (i_COUNT),
        .i_wr_word  (wr_chan[ch] & i_WORD),
        .i_wr_low   (wr_chan[ch] & ~i_WORD),
        .i_wdata    (i_WDATA),
        .o_value    (chan_value[ch]),
        .o_irq      (chan_irq[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Compare-one, clear and reload
  // ----------------------------------------------------------------
  // Only the first cycle of a match counts, so a stalled counter gives one pulse
  wire cm1_match = (compare_one_reg == i_COUNT);
  wire cm1_rise  = cm1_match & ~cm1_prev_reg;
  wire cm1_irq_next = cm1_rise & (~mode_b | i_COUNT_DOWN);

  // Clear sources per mode; mode B never looks at the clear bits
  wire clr_a_ext = (clr_src == udcc_pkg::UDCC_CLR_EXT_ONLY) |
                   (clr_src == udcc_pkg::UDCC_CLR_EITHER);
  wire clr_a_cm0 = (clr_src == udcc_pkg::UDCC_CLR_CM0) |
                   (clr_src == udcc_pkg::UDCC_CLR_EITHER);
  wire clear_gp  = ~operating_mode & clear_enable & i_COMPARE_ZERO_MATCH;
  wire clear_a   = mode_a & ((clr_a_ext & i_EXT_CLEAR) |
                             (clr_a_cm0 & i_COMPARE_ZERO_MATCH & counting_up));
  wire clear_b   = mode_b & ((i_COMPARE_ZERO_MATCH & counting_up) |
                             (cm1_rise & i_COUNT_DOWN));
  wire clear_next  = clear_gp | clear_a | clear_b;
  wire reload_next = mode_a & reload_enable & i_UNDERFLOW;

  // Inactive level is the opposite of the active one, i.e. the polarity bit
  wire timer_out_next = (~operating_mode & timer_out_en) ? (i_PWM_ACTIVE ^ polarity)
                                                         : polarity;

  // Output flops and pulses
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cm1_prev_reg  <= 1'b0;
      cm1_irq_reg   <= 1'b0;
      clear_reg     <= 1'b0;
      reload_reg    <= 1'b0;
      timer_out_reg <= 1'b0;
    end else begin
      cm1_prev_reg  <= cm1_match;
      cm1_irq_reg   <= cm1_irq_next;
      clear_reg     <= clear_next;
      reload_reg    <= reload_next;
      timer_out_reg <= timer_out_next;
    end
  end

  assign o_RDATA           = rdata_reg;
  assign o_COUNT_ENABLE    = count_control_reg[udcc_pkg::CC_COUNT_ENABLE_BIT];
  assign o_OPERATING_MODE  = unit_mode_reg[udcc_pkg::UM_OPERATING_MODE_BIT];
  assign o_SUB_MODE        = unit_mode_reg[udcc_pkg::UM_SUB_MODE_BIT];
  assign o_CLEAR           = clear_reg;
  assign o_RELOAD          = reload_reg;
  assign o_TIMER_OUT       = timer_out_reg;
  assign o_COMPARE_ONE_IRQ = cm1_irq_reg;
  assign o_CHAN_ZERO_IRQ   = chan_irq[0];
  assign o_CHAN_ONE_IRQ    = chan_irq[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  a_cm1_irq_always: assert property ((cm1_rise && !mode_b) |=> o_COMPARE_ONE_IRQ)
    else $error("compare-one match gave no interrupt");
  a_cm1_irq_down_only: assert property ((cm1_rise && mode_b && !i_COUNT_DOWN)
                                        |=> !o_COMPARE_ONE_IRQ)
    else $error("mode B up-count match raised compare-one interrupt");
  a_cm1_low_byte: assert property ((wr_cm1 && !i_WORD) |=>
                                   (compare_one_reg[15:8] == $past(compare_one_reg[15:8]))
                                   && (compare_one_reg[7:0] == $past(i_WDATA[7:0])))
    else $error("low byte write to compare-one wrong");
  a_cm1_irq_single: assert property (o_COMPARE_ONE_IRQ |=> !o_COMPARE_ONE_IRQ)
    else $error("compare-one interrupt longer than one cycle");
  a_chan0_pin_lost: assert property ((operating_mode && !capcomp_mode_reg[0]) |=>
                                     !o_CHAN_ZERO_IRQ)
    else $error("channel zero captured in up/down mode");
  a_gp_clear_match: assert property ((!operating_mode && i_COMPARE_ZERO_MATCH)
                                     |=> (o_CLEAR == $past(clear_enable)))
    else $error("timer mode clear does not follow clear enable");
  a_mode_b_clear: assert property ((mode_b && i_COMPARE_ZERO_MATCH && !i_COUNT_DOWN)
                                   |=> o_CLEAR)
    else $error("mode B up-count compare-zero match did not clear");
  a_clear_none: assert property ((mode_a && clr_src == udcc_pkg::UDCC_CLR_NONE) |=> !o_CLEAR)
    else $error("clear with clear source set to none");
  a_reload_mode_a: assert property (o_RELOAD |-> $past(mode_a && reload_enable && i_UNDERFLOW))
    else $error("reload outside mode A underflow");
  a_timer_out_udc: assert property (operating_mode |=> (o_TIMER_OUT == $past(polarity)))
    else $error("timer output not inactive in up/down mode");


  // Mode A clear and reload paths; a missed down-count gate would clear on a
  // direction change the software never asked for
  a_ext_clear: assert property ((mode_a && clr_a_ext && i_EXT_CLEAR) |=> o_CLEAR)
    else $error("mode A external clear did not clear");
  a_down_no_clear: assert property ((mode_a && i_COUNT_DOWN && !i_EXT_CLEAR)
                                    |=> !o_CLEAR)
    else $error("mode A cleared while counting down");
  a_reload_off: assert property (!reload_enable |=> !o_RELOAD)
    else $error("reload with reload disabled");
  a_reload_underflow: assert property ((mode_a && reload_enable && i_UNDERFLOW)
                                       |=> o_RELOAD)
    else $error("mode A underflow did not reload");

  // Mode B and shared pins: the clear bits and the lost pins must stay inert
  a_b_ignores_bits: assert property ((mode_b && !i_COMPARE_ZERO_MATCH &&
                                      !(cm1_rise && i_COUNT_DOWN)) |=> !o_CLEAR)
    else $error("mode B cleared from the clear bits");
  a_chan1_pin_lost: assert property ((clear_pin_used && !capcomp_mode_reg[1]) |=>
                                     !o_CHAN_ONE_IRQ)
    else $error("channel one captured while its pin is the clear input");

  c_cm1_irq: cover property (o_COMPARE_ONE_IRQ);
  c_clear_b: cover property (mode_b && o_CLEAR);
  c_reload:  cover property (o_RELOAD);

endmodule

`default_nettype wire

// [shared/udcc_pkg.sv]
// Purpose : Constants for the capture/compare and mode-control slice of the up/down counter
// Assumes : 16-bit CPU memory port, 8-bit control registers, 16-bit value registers
// Notes   : Offsets, bit positions, reset values and encodings live here only

`default_nettype none

package udcc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CAPCOMP_MODE  = 16'hff94;
  localparam logic [15:0] ADDR_UNIT_MODE     = 16'hff95;
  localparam logic [15:0] ADDR_COUNT_CONTROL = 16'hff96;
  localparam logic [15:0] ADDR_CAPCOMP_ZERO  = 16'hff40;
  localparam logic [15:0] ADDR_CAPCOMP_ONE   = 16'hff42;
  localparam logic [15:0] ADDR_COMPARE_ONE   = 16'hff44;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UM_OPERATING_MODE_BIT = 7;
  localparam int UM_TIMER_OUT_EN_BIT   = 3;
  localparam int UM_POLARITY_BIT       = 2;
  localparam int UM_SUB_MODE_BIT       = 0;
  localparam int CC_COUNT_ENABLE_BIT   = 6;
  localparam int CC_RELOAD_ENABLE_BIT  = 3;
  localparam int CC_CLEAR_ENABLE_BIT   = 2;
  localparam int CC_CLEAR_SRC_HI_BIT   = 1;
  localparam int CC_CLEAR_SRC_LO_BIT   = 0;
  localparam int CCR_CHAN_ZERO_BIT     = 0;
  localparam int CCR_CHAN_ONE_BIT      = 1;

  // Writable bits; the rest read as zero
  localparam logic [7:0] UNIT_MODE_MASK     = 8'h8d;
  localparam logic [7:0] COUNT_CONTROL_MASK = 8'h4f;
  localparam logic [7:0] CAPCOMP_MODE_MASK  = 8'h03;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  UNIT_MODE_RST     = 8'h00;
  localparam logic [7:0]  COUNT_CONTROL_RST = 8'h00;
  localparam logic [7:0]  CAPCOMP_MODE_RST  = 8'h00;
  localparam logic [15:0] VALUE_RST         = 16'h0000;
  localparam logic [15:0] RDATA_RST         = 16'h0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UDCC_EDGE_FALL = 2'h0,
    UDCC_EDGE_RISE = 2'h1,
    UDCC_EDGE_NONE = 2'h2,
    UDCC_EDGE_BOTH = 2'h3
  } udcc_edge_t;

  typedef enum logic [1:0] {
    UDCC_CLR_EXT_ONLY = 2'h0,
    UDCC_CLR_CM0      = 2'h1,
    UDCC_CLR_EITHER   = 2'h2,
    UDCC_CLR_NONE     = 2'h3
  } udcc_clr_src_t;

endpackage

`default_nettype wire

// [hdl/udcc_chan.sv]
// Purpose : One capture/compare channel: value register, edge trigger, match pulse
// Assumes : Capture pin synchronous to the clock; counter value from the counter core
// Notes   : Capture outranks a CPU write landing in the same cycle

`timescale 1ns/10ps
`default_nettype none

module udcc_chan (
  input  wire logic        i_clk,        // System clock
  input  wire logic        i_rst,        // Synchronous reset, active high
  input  wire logic        i_pin,        // Capture pin level
  input  wire logic [1:0]  i_edge_sel,   // Active edge selection
  input  wire logic        i_cap_en,     // Capture allowed (counting, pin free)
  input  wire logic        i_cmp_mode,   // 1 = compare, 0 = capture
  input  wire logic [15:0] i_count,      // Counter value
  input  wire logic        i_wr_word,    // CPU word write
  input  wire logic        i_wr_low,     // CPU low byte write
  input  wire logic [15:0] i_wdata,      // CPU write data
  output logic      [15:0] o_value,      // Register contents
  output logic             o_irq         // Channel interrupt pulse
);

  logic        pin_prev_reg;
  logic        match_prev_reg;
  logic [15:0] value_reg;
  logic [15:0] value_next;
  logic        irq_reg;
  logic        irq_next;

  // ----------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------
  wire rise_seen = i_pin & ~pin_prev_reg;
  wire fall_seen = ~i_pin & pin_prev_reg;
  wire edge_ok   = (i_edge_sel == udcc_pkg::UDCC_EDGE_RISE) ? rise_seen :
                   (i_edge_sel == udcc_pkg::UDCC_EDGE_FALL) ? fall_seen :
                   (i_edge_sel == udcc_pkg::UDCC_EDGE_BOTH) ? (rise_seen | fall_seen) : 1'b0;
  wire cap_fire  = ~i_cmp_mode & i_cap_en & edge_ok;
  wire match     = i_cmp_mode & (value_reg == i_count);
  wire match_hit = match & ~match_prev_reg;

  // Writes in capture mode are dropped so a captured value is never corrupted
  assign value_next = cap_fire                 ? i_count :
                      (i_wr_word & i_cmp_mode) ? i_wdata :
                      (i_wr_low & i_cmp_mode)  ? {value_reg[15:8], i_wdata[7:0]} :
                      value_reg;
  assign irq_next   = cap_fire | match_hit;

  // Channel state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev_reg   <= 1'b0;
      match_prev_reg <= 1'b0;
      value_reg      <= udcc_pkg::VALUE_RST;
      irq_reg        <= 1'b0;
    end else begin
      pin_prev_reg   <= i_pin;
      match_prev_reg <= match;
      value_reg      <= value_next;
      irq_reg        <= irq_next;
    end
  end

  assign o_value = value_reg;
  assign o_irq   = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_capture_latches_count: assert property (cap_fire |=> (value_reg == $past(i_count)) && o_irq)
    else $error("capture did not latch count or raise interrupt");
  a_capture_held_off: assert property ((!i_cap_en && !i_cmp_mode && !match_prev_reg) |=> !o_irq)
    else $error("interrupt while capture disabled");
  a_compare_match_irq: assert property ((i_cmp_mode && value_reg == i_count && !match_prev_reg)
                                        |=> o_irq)
    else $error("compare match gave no interrupt");
  a_capture_mode_write: assert property ((!i_cmp_mode && !cap_fire) |=> $stable(value_reg))
    else $error("capture register changed without trigger");

  c_capture_seen: cover property (cap_fire);
  c_compare_seen: cover property (match_hit);

endmodule

`default_nettype wire

// [dv/udcc_pins_model.sv]
// Purpose : Far-side model: counter value, count direction and capture pin levels
// Assumes : The bench calls the tasks just after a falling clock edge
// Notes   : The counter is held still so a captured value is known exactly
`timescale 1ns/10ps
`default_nettype none
module udcc_pins_model (
  output logic [15:0] o_count, // Counter value seen by the block
  output logic        o_down,  // Counting down
  output logic [1:0]  o_pin    // Capture pin levels, one bit per channel
);
  // Pins start low, like pulled-down inputs before any edge
  initial begin
    o_count = 16'h0000;
    o_down = 1'b0;
    o_pin = 2'h0;
  end
  task automatic put(input logic [15:0] v, input logic dn);
    o_count = v;
    o_down = dn;
  endtask
  // One toggle is one edge on that pin
  task automatic tog(input int ch);
    o_pin[ch] = ~o_pin[ch];
  endtask
endmodule
`default_nettype wire

// [dv/udcc_top_tb.sv]
// Purpose : Self-checking bench for the capture/compare and mode-control block
// Assumes : One-cycle strobes, all inputs changed on falling edges
// Notes   : Counter values are random from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module udcc_top_tb;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, word = 1'b1, e;
  logic        cz = 1'b0, uf = 1'b0, xc = 1'b0, pwm = 1'b1;
  logic        down, ce, om, sm, clr, rl, tout, i1, i0, ic1;
  logic [1:0]  es = 2'h1, pin;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, v, cnt, rdata;
  int          fails = 0, checks_done = 0, cyc = 0;
  udcc_pins_model u_enc (.o_count(cnt), .o_down(down), .o_pin(pin));
  udcc_top u_dut (.I_CLOCK(clk), .I_RST(rst), .i_ADDR(addr), .i_WDATA(wdata), .i_WR(wr),
    .i_RD(rd), .i_WORD(word), .i_COUNT(cnt), .i_COUNT_DOWN(down), .i_COMPARE_ZERO_MATCH(cz),
    .i_UNDERFLOW(uf), .i_EXT_CLEAR(xc), .i_PWM_ACTIVE(pwm), .i_CHAN_ZERO_CAPTURE_PIN(pin[0]),
    .i_CHAN_ONE_CAPTURE_PIN(pin[1]), .i_CHAN_ZERO_EDGE_SEL(es), .i_CHAN_ONE_EDGE_SEL(es),
    .o_RDATA(rdata), .o_COUNT_ENABLE(ce), .o_OPERATING_MODE(om), .o_SUB_MODE(sm),
    .o_CLEAR(clr), .o_RELOAD(rl), .o_TIMER_OUT(tout), .o_COMPARE_ONE_IRQ(i1),
    .o_CHAN_ZERO_IRQ(i0), .o_CHAN_ONE_IRQ(ic1));
  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, d, input logic w);
    @(negedge clk);
    {addr, wdata, word, wr} = {a, d, w, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data is registered, so it is compared one cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, x, input logic w);
    @(negedge clk);
    {addr, word, rd} = {a, w, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    chk($sformatf("rdata %h", a), x, rdata);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    v = 16'($urandom(29855));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_chk(udcc_pkg::ADDR_COMPARE_ONE, 16'h0000, 1'b1);
    wr_reg(udcc_pkg::ADDR_COMPARE_ONE, v, 1'b1);
    rd_chk(udcc_pkg::ADDR_COMPARE_ONE, v, 1'b1);
    wr_reg(udcc_pkg::ADDR_COMPARE_ONE, ~v, 1'b0);
    v = {v[15:8], ~v[7:0]};
    rd_chk(udcc_pkg::ADDR_COMPARE_ONE, v, 1'b1);
    // Mode B with clear and reload enables set, external clear source: only the down-count match may clear
    wr_reg(udcc_pkg::ADDR_UNIT_MODE, 16'h00ff, 1'b0); // mode set before counting
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h004c, 1'b0);
    rd_chk(udcc_pkg::ADDR_UNIT_MODE, {8'h00, udcc_pkg::UNIT_MODE_MASK}, 1'b0);
    chk("modes", 16'h0007, {13'h0, ce, om, sm});
    for (int dn = 0; dn < 2; dn++) begin
      u_enc.put(v + 16'h1, dn[0]);
      @(negedge clk);
      u_enc.put(v, dn[0]);
      {xc, uf} = 2'h3;
      @(negedge clk);
      {xc, uf} = 2'h0;
      chk("cm1_irq_clr_reload", dn ? 16'h0006 : 16'h0000, {13'h0, i1, clr, rl});
    end
    chk("tout_udc", 16'h0001, {15'h0, tout});
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0000, 1'b0);
    for (int p = 0; p < 2; p++) begin
      pwm = 1'($urandom);
      wr_reg(udcc_pkg::ADDR_UNIT_MODE, 16'h0008 | 16'(p << 2), 1'b0);
      @(negedge clk);
      chk("tout", {15'h0, pwm ^ p[0]}, {15'h0, tout});
    end
    // Captures on both channels for every edge code, rising and falling
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0040, 1'b0);
    for (int i = 0; i < 8; i++) begin
      es = 2'(i >> 1);
      u_enc.put(16'($urandom), 1'b0);
      u_enc.tog(0);
      u_enc.tog(1);
      e = (es == 2'h3) || (es == {1'b0, pin[0]});
      @(negedge clk);
      chk("cap_irq", {14'h0, e, e}, {14'h0, ic1, i0});
      if (e) rd_chk(udcc_pkg::ADDR_CAPCOMP_ZERO, cnt, 1'b1);
      if (e) rd_chk(udcc_pkg::ADDR_CAPCOMP_ONE, cnt, 1'b1); // other read between
    end
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0000, 1'b0);
    u_enc.tog(0);
    @(negedge clk);
    chk("cap_off", 16'h0000, {14'h0, ic1, i0});
    // Both channels to compare with fresh values, then match each in turn
    wr_reg(udcc_pkg::ADDR_CAPCOMP_MODE, 16'h0003, 1'b0);
    wr_reg(udcc_pkg::ADDR_CAPCOMP_ZERO, v, 1'b1);
    wr_reg(udcc_pkg::ADDR_CAPCOMP_ONE, ~v, 1'b1);
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0040, 1'b0); // no writes after this
    for (int k = 0; k < 2; k++) begin
      u_enc.put(k ? ~v : v, 1'b0);
      @(negedge clk);
      chk("cmp_irq", k ? 16'h0002 : 16'h0005, {13'h0, i1, ic1, i0});
    end
    // Mode A, reload on, clear by pin or by compare-zero while counting up
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0000, 1'b0);
    wr_reg(udcc_pkg::ADDR_UNIT_MODE, 16'h0080, 1'b0); // mode set while stopped
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h004a, 1'b0);
    for (int s = 0; s < 3; s++) begin
      u_enc.put(cnt, s == 1);
      {xc, uf, cz} = (s == 0) ? 3'h6 : 3'h1;
      @(negedge clk);
      {xc, uf, cz} = 3'h0;
      chk("clr_reload_a", (s == 0) ? 16'h0003 : ((s == 2) ? 16'h0002 : 16'h0000),
          {14'h0, clr, rl});
    end
    // Timer mode with clear enable: compare-zero match clears
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0000, 1'b0);
    wr_reg(udcc_pkg::ADDR_UNIT_MODE, 16'h0000, 1'b0);
    wr_reg(udcc_pkg::ADDR_COUNT_CONTROL, 16'h0044, 1'b0);
    cz = 1'b1;
    @(negedge clk);
    cz = 1'b0;
    chk("clr_gp", 16'h0001, {15'h0, clr});
    print_verdict();
  end
endmodule
`default_nettype wire
